// [bench/mpr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module mpr_host (
   input  wire logic                       clk,        // bank clock
   output logic                            reg_write,  // write strobe
   output logic                            reg_read,   // read strobe
   output logic      [mpr_pkg::ADDR_W-1:0] reg_addr,   // offset
   output logic      [mpr_pkg::DATA_W-1:0] reg_wdata,  // write word
   input  wire logic [mpr_pkg::DATA_W-1:0] reg_rdata,  // read word
   input  wire logic                       reg_rvalid  // read answer
);
   import mpr_pkg::*;
   // idle bus at time zero
   initial begin
      reg_write = 1'b0;
      reg_read  = 1'b0;
      reg_addr  = '0;
      reg_wdata = '0;
   end
   // one write, launched and released on falling edges
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk);
      reg_write = 1'b0;
      reg_addr  = ~a;  // released lines never keep the old value
      reg_wdata = ~d;
   endtask : wr
   // one read, answer sampled half a cycle after the taking edge
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
      @(negedge clk);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clk);
      reg_read = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
      v        = reg_rvalid;
   endtask : rd
endmodule : mpr_host
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import mpr_pkg::*;
   logic              clk, rst_n, reg_write, reg_read, reg_rvalid, soft_reset_pulse;
   logic              fractional_mode, integer_mode;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, block_power_enables, integer_divider, fractional_divider;
   logic [DATA_W-1:0] divider_modulus, power_enable_mask, charge_pump_control, phase_detector_control;
   logic [DATA_W-1:0] oscillator_control, output_balun_tuning, modulator_linearity, modulator_phase_polarity;
   logic [DATA_W-1:0] modulator_offset_trim, detector_pump_timing, dither_control, dither_seed_low;
   logic [DATA_W-1:0] oscillator_band_control, oscillator_settings, got;
   logic              v;
   logic [DATA_W-1:0] outs [NUM_REGS];  // live words in table order
   assign outs = '{16'h0000, block_power_enables, integer_divider, fractional_divider, divider_modulus,
      power_enable_mask, charge_pump_control, phase_detector_control, oscillator_control,
      output_balun_tuning, modulator_linearity, modulator_phase_polarity, modulator_offset_trim,
      detector_pump_timing, dither_control, dither_seed_low, oscillator_band_control, oscillator_settings};
   int                err_total, checks_done, cycles;
   mpr_register_bank i_dut (.clk, .rst_n, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .soft_reset_pulse, .fractional_mode, .integer_mode, .block_power_enables,
      .integer_divider, .fractional_divider, .divider_modulus, .power_enable_mask, .charge_pump_control,
      .phase_detector_control, .oscillator_control, .output_balun_tuning, .modulator_linearity,
      .modulator_phase_polarity, .modulator_offset_trim, .detector_pump_timing, .dither_control,
      .dither_seed_low, .oscillator_band_control, .oscillator_settings);
   mpr_host i_host (.clk, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
   // 20 mhz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // optional write of every word but the reset word, then read back all against expectation
   task automatic sweep(input logic [DATA_W-1:0] pat, input logic do_wr);
      logic [DATA_W-1:0] e;
      for (int i = 1; i < NUM_REGS; i++) begin
         if (do_wr) i_host.wr(REG_OFFSET[i], pat);
      end
      i_host.wr(7'h7F, pat);  // unmapped write, ignored
      for (int i = 0; i < NUM_REGS; i++) begin
         e = do_wr ? ((REG_RESET[i] & ~REG_WMASK[i]) | (pat & REG_WMASK[i])) : REG_RESET[i];
         if (i == IDX_SWRST) e = 16'h0000;
         i_host.rd(REG_OFFSET[i], got, v);
         chk({15'h0000, v}, 16'h0001);
         chk(got, e);
         chk(outs[i], e);
      end
      i_host.rd(7'h7F, got, v);
      chk(got, 16'h0000);
      $display("test sweep %h done", pat);
   endtask : sweep
   // verdict in one place
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         give_verdict();
      end
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      sweep(16'h0000, 1'b0);
      sweep(16'hFFFF, 1'b1);
      chk({14'h0000, integer_mode, fractional_mode}, 16'h0002);
      sweep(16'h0000, 1'b1);
      chk({14'h0000, integer_mode, fractional_mode}, 16'h0001);
      chk(fractional_divider, 16'h0000);
      $display("test divider mode done");
      i_host.wr(7'h00, 16'hFFFF);
      chk({15'h0000, soft_reset_pulse}, 16'h0001);
      chk(block_power_enables, 16'hF67F);
      chk(oscillator_settings, 16'h16BD);
      @(negedge clk);
      chk({15'h0000, soft_reset_pulse}, 16'h0000);
      $display("test soft reset done");
      sweep(16'h0000, 1'b0);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire

// [rtl/mpr_pkg.sv]
// Operation
// RULE1: write-only soft reset word, bit 0
// RULE2: eleven power enables, bits 11 to 1
// RULE3: divider mode bit plus 11-bit integer divide
// RULE4: mode zero fractional, one integer
// RULE5: 16-bit fractional divide value
// RULE6: 16-bit divider modulus value
// RULE7: enable mask mirrors power enable bits
// RULE8: charge pump select, scale and bleed
// RULE9: detector mux, polarity and reference select
// RULE10: oscillator regulator, drive and divider enables
// RULE11: balun output and input capacitance nibbles; the code keeps the whole word read-only at zero
// RULE12: linearity resistor and capacitor selects
// RULE13: modulator bleed, polarities, phase trims
// RULE14: inphase and quadrature dc offset trims
// RULE15: antibacklash delay, pump control, edge select
// RULE16: dither enable, magnitude, seed top bit
// RULE17: lower sixteen bits of dither seed
// RULE18: tune voltage, band source, band value
// RULE19: two oscillator setting fields
// RULE20: soft reset restores all, bit self-clears
// RULE21: reserved bits keep reset value
package mpr_pkg;
   localparam int DATA_W   = 16;              // register word width
   localparam int ADDR_W   = 7;               // register offset width
   localparam int NUM_REGS = 18;              // entries in the bank
   // register indices into the bank
   localparam int IDX_SWRST = 0;
   localparam int IDX_PWR   = 1;
   localparam int IDX_INT   = 2;
   localparam int IDX_FRAC  = 3;
   localparam int IDX_MODU  = 4;
   localparam int IDX_MASK  = 5;
   localparam int IDX_BALUN = 9;
   // single-bit field positions
   localparam int SWRST_BIT    = 0;           // soft reset trigger
   localparam int DIV_MODE_BIT = 11;          // 0 fractional, 1 integer
   // printed offsets, one per entry
   localparam logic [ADDR_W-1:0] REG_OFFSET [NUM_REGS] = '{
      7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h10, 7'h20, 7'h21, 7'h22,
      7'h30, 7'h31, 7'h32, 7'h33, 7'h40, 7'h42, 7'h43, 7'h45, 7'h49};
   // reset values
   localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
      16'h0000, 16'hF67F, 16'h002C, 16'h0128, 16'h0600, 16'hF67F,
      16'h0C26, 16'h000B, 16'h2A03, 16'h0000, 16'h1101, 16'h0900,
      16'h0000, 16'h0010, 16'h000E, 16'h0000, 16'h0000, 16'h16BD};
   // bits that software may change; all others are reserved or read-only
   localparam logic [DATA_W-1:0] REG_WMASK [NUM_REGS] = '{
      16'h0000, 16'h0FFE, 16'h0FFF, 16'hFFFF, 16'hFFFF, 16'h0FFE,
      16'h7C3F, 16'h007F, 16'hFFFF, 16'h0000, 16'h1FFF, 16'h7FFF,
      16'hFFFF, 16'h007F, 16'h000F, 16'hFFFF, 16'h03FF, 16'h3FFF};
endpackage : mpr_pkg

// [rtl/mpr_register_bank.sv]
`timescale 1ns/100ps
`default_nettype none
module mpr_register_bank
   import mpr_pkg::*;
(
   input  wire logic                       clk,                 // 20 MHz
   input  wire logic                       rst_n,               // sync, active low
   input  wire logic                       reg_write,           // write strobe
   input  wire logic                       reg_read,            // read strobe
   input  wire logic [mpr_pkg::ADDR_W-1:0] reg_addr,            // register offset
   input  wire logic [mpr_pkg::DATA_W-1:0] reg_wdata,           // write data
   output logic      [mpr_pkg::DATA_W-1:0] reg_rdata,           // read data, flop
   output logic                            reg_rvalid,          // read answer pulse
   output logic                            soft_reset_pulse,    // one cycle after trigger
   output logic                            fractional_mode,     // divider in fractional-n
   output logic                            integer_mode,        // divider in integer-n
   output logic      [mpr_pkg::DATA_W-1:0] block_power_enables,
   output logic      [mpr_pkg::DATA_W-1:0] integer_divider,
   output logic      [mpr_pkg::DATA_W-1:0] fractional_divider,
   output logic      [mpr_pkg::DATA_W-1:0] divider_modulus,
   output logic      [mpr_pkg::DATA_W-1:0] power_enable_mask,
   output logic      [mpr_pkg::DATA_W-1:0] charge_pump_control,
   output logic      [mpr_pkg::DATA_W-1:0] phase_detector_control,
   output logic      [mpr_pkg::DATA_W-1:0] oscillator_control,
   output logic      [mpr_pkg::DATA_W-1:0] output_balun_tuning,
   output logic      [mpr_pkg::DATA_W-1:0] modulator_linearity,
   output logic      [mpr_pkg::DATA_W-1:0] modulator_phase_polarity,
   output logic      [mpr_pkg::DATA_W-1:0] modulator_offset_trim,
   output logic      [mpr_pkg::DATA_W-1:0] detector_pump_timing,
   output logic      [mpr_pkg::DATA_W-1:0] dither_control,
   output logic      [mpr_pkg::DATA_W-1:0] dither_seed_low,
   output logic      [mpr_pkg::DATA_W-1:0] oscillator_band_control,
   output logic      [mpr_pkg::DATA_W-1:0] oscillator_settings
);
   import mpr_pkg::*;

   logic [DATA_W-1:0] regs_q   [NUM_REGS];  // bank storage
   logic [DATA_W-1:0] rd_term  [NUM_REGS];  // per-entry read contribution
   logic [NUM_REGS-1:0] wr_hit;             // per-entry write decode
   logic [NUM_REGS-1:0] rd_hit;             // per-entry offset match
   logic              soft_hit;             // soft reset trigger this cycle
   logic [DATA_W-1:0] rdata_d;              // next read data
   logic              soft_q;               // registered trigger

   // soft reset trigger: write to the reset word with bit 0 set
   assign soft_hit = reg_write && (reg_addr == REG_OFFSET[IDX_SWRST])
                     && reg_wdata[SWRST_BIT];  // [RULE1]

   // per-entry storage, decode and read term
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      assign wr_hit[g] = reg_write && (reg_addr == REG_OFFSET[g]);
      // only unreserved bits take the write
      always_ff @(posedge clk) begin
         if (!rst_n || soft_hit) begin
            regs_q[g] <= REG_RESET[g];                         // [RULE20]
         end else if (wr_hit[g]) begin
            regs_q[g] <= (regs_q[g] & ~REG_WMASK[g])
                         | (reg_wdata & REG_WMASK[g]);         // [RULE21]
         end
      end
      // reset word stores nothing, so it reads zero
      assign rd_hit[g]  = (reg_addr == REG_OFFSET[g]);
      assign rd_term[g] = rd_hit[g] ? regs_q[g] : '0;
   end

   // read mux: unmapped offsets read zero
   always_comb begin
      rdata_d = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         rdata_d = rdata_d | rd_term[i];
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= rdata_d;
         end
      end
   end

   // trigger is not retained, only echoed for one cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         soft_q <= 1'b0;
      end else begin
         soft_q <= soft_hit;                                   // [RULE20]
      end
   end
   assign soft_reset_pulse = soft_q;

   // divider mode decode
   assign integer_mode    = integer_divider[DIV_MODE_BIT];    // [RULE4]
   assign fractional_mode = ~integer_divider[DIV_MODE_BIT];   // [RULE4]

   // control words to the analog blocks
   assign block_power_enables      = regs_q[IDX_PWR];         // [RULE2]
   assign integer_divider          = regs_q[IDX_INT];         // [RULE3]
   assign fractional_divider       = regs_q[IDX_FRAC];        // [RULE5]
   assign divider_modulus          = regs_q[IDX_MODU];        // [RULE6]
   assign power_enable_mask        = regs_q[IDX_MASK];        // [RULE7]
   assign charge_pump_control      = regs_q[6];               // [RULE8]
   assign phase_detector_control   = regs_q[7];               // [RULE9]
   assign oscillator_control       = regs_q[8];               // [RULE10]
   assign output_balun_tuning      = regs_q[IDX_BALUN];       // [RULE11]
   assign modulator_linearity      = regs_q[10];              // [RULE12]
   assign modulator_phase_polarity = regs_q[11];              // [RULE13]
   assign modulator_offset_trim    = regs_q[12];              // [RULE14]
   assign detector_pump_timing     = regs_q[13];              // [RULE15]
   assign dither_control           = regs_q[14];              // [RULE16]
   assign dither_seed_low          = regs_q[15];              // [RULE17]
   assign oscillator_band_control  = regs_q[16];              // [RULE18]
   assign oscillator_settings      = regs_q[17];              // [RULE19]

   // soft reset returns live registers to reset values
   property p_soft_restore;
      @(posedge clk) disable iff (!rst_n)
      soft_hit |=> (charge_pump_control == REG_RESET[6])
                   && (block_power_enables == REG_RESET[IDX_PWR]);
   endproperty
   a_soft_restore: assert property (p_soft_restore) else $error("soft reset did not restore"); // [RULE20]

   // enable write keeps reserved bits
   property p_pwr_write;
      @(posedge clk) disable iff (!rst_n)
      (wr_hit[IDX_PWR] && !soft_hit) |=> block_power_enables ==
         (($past(reg_wdata) & REG_WMASK[IDX_PWR]) | (REG_RESET[IDX_PWR] & ~REG_WMASK[IDX_PWR]));
   endproperty
   a_pwr_write: assert property (p_pwr_write) else $error("enable write wrong"); // [RULE2]

   // mask write mirrors the enable layout
   property p_mask_write;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[IDX_MASK] |=> power_enable_mask[0] && (power_enable_mask[15:12] == 4'hF)
         && (power_enable_mask[11:1] == $past(reg_wdata[11:1]));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write wrong"); // [RULE7]

   // integer divider upper bits stay reserved
   property p_int_reserved;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[IDX_INT] |=> (integer_divider[15:12] == 4'h0)
         && (integer_divider[11:0] == $past(reg_wdata[11:0]));
   endproperty
   a_int_reserved: assert property (p_int_reserved) else $error("integer divider write wrong"); // [RULE3]

   // mode decode follows the stored bit
   property p_mode;
      @(posedge clk) disable iff (!rst_n)
      (integer_mode != fractional_mode) && (integer_mode == integer_divider[DIV_MODE_BIT]);
   endproperty
   a_mode: assert property (p_mode) else $error("divider mode decode wrong"); // [RULE4]

   // full-width fraction and modulus
   property p_full_words;
      @(posedge clk) disable iff (!rst_n)
      (wr_hit[IDX_FRAC] ##1 wr_hit[IDX_MODU]) |=>
         (divider_modulus == $past(reg_wdata)) && (fractional_divider == $past(reg_wdata, 2));
   endproperty
   a_full_words: assert property (p_full_words) else $error("fraction or modulus lost"); // [RULE5] [RULE6]

   // balun word never moves off zero
   property p_balun;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[IDX_BALUN] |=> output_balun_tuning == 16'h0000 [*2];
   endproperty
   a_balun: assert property (p_balun) else $error("balun word changed"); // [RULE11]

   // reset word reads back zero
   property p_swrst_read;
      @(posedge clk) disable iff (!rst_n)
      (reg_read && reg_addr == REG_OFFSET[IDX_SWRST]) |=> reg_rvalid && (reg_rdata == 16'h0000);
   endproperty
   a_swrst_read: assert property (p_swrst_read) else $error("reset word read nonzero"); // [RULE1]

   // pulse follows trigger and lasts one cycle
   property p_pulse;
      @(posedge clk) disable iff (!rst_n)
      soft_hit |=> soft_reset_pulse ##1 (!soft_reset_pulse || $past(soft_hit));
   endproperty
   a_pulse: assert property (p_pulse) else $error("soft reset pulse wrong"); // [RULE20]

   // reserved bits of every entry hold their reset value
   for (genvar r = 0; r < NUM_REGS; r++) begin : g_rsv
      property p_reserved;
         @(posedge clk) disable iff (!rst_n)
         (regs_q[r] & ~REG_WMASK[r]) == (REG_RESET[r] & ~REG_WMASK[r]);
      endproperty
      a_reserved: assert property (p_reserved) else $error("reserved bits moved"); // [RULE21]
   end

   // charge pump select, scale and bleed take the write
   property p_cp_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[6] |=> (charge_pump_control[14:10] == $past(reg_wdata[14:10]))
         && (charge_pump_control[5:0] == $past(reg_wdata[5:0]));
   endproperty
   a_cp_fields: assert property (p_cp_fields) else $error("pump fields wrong"); // [RULE8]

   // charge pump gaps stay at zero
   property p_cp_reserved;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[6] |=> (charge_pump_control[15] == 1'b0)
         && (charge_pump_control[9:6] == 4'h0);
   endproperty
   a_cp_reserved: assert property (p_cp_reserved) else $error("pump reserved bits moved"); // [RULE8]

   // detector low bits take the write, upper part stays zero
   property p_pfd_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[7] |=> (phase_detector_control[6:0] == $past(reg_wdata[6:0]))
         && (phase_detector_control[15:7] == 9'h000);
   endproperty
   a_pfd_fields: assert property (p_pfd_fields) else $error("detector fields wrong"); // [RULE9]

   // oscillator word is fully writable
   property p_osc_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[8] |=>
         oscillator_control == $past(reg_wdata);
   endproperty
   a_osc_fields: assert property (p_osc_fields) else $error("oscillator word wrong"); // [RULE10]

   // divider enables at bits 5 to 3
   property p_osc_enables;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[8] |=>
         oscillator_control[5:3] == $past(reg_wdata[5:3]);
   endproperty
   a_osc_enables: assert property (p_osc_enables) else $error("divider enables wrong"); // [RULE10]

   // balun word reads back zero
   property p_balun_read;
      @(posedge clk) disable iff (!rst_n)
      (reg_read && rd_hit[IDX_BALUN]) |=>
         reg_rvalid && (reg_rdata == 16'h0000);
   endproperty
   a_balun_read: assert property (p_balun_read) else $error("balun read nonzero"); // [RULE11]

   // linearity selects take the write, top bits stay zero
   property p_lin_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[10] |=> (modulator_linearity[12:0] == $past(reg_wdata[12:0]))
         && (modulator_linearity[15:13] == 3'h0);
   endproperty
   a_lin_fields: assert property (p_lin_fields) else $error("linearity fields wrong"); // [RULE12]

   // bleed, polarities and phase trims take the write
   property p_modctl_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[11] |=> (modulator_phase_polarity[14:0] == $past(reg_wdata[14:0]))
         && (modulator_phase_polarity[15] == 1'b0);
   endproperty
   a_modctl_fields: assert property (p_modctl_fields) else $error("modulator fields wrong"); // [RULE13]

   // both offset trims take the write
   property p_trim_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[12] |=> (modulator_offset_trim[15:8] == $past(reg_wdata[15:8]))
         && (modulator_offset_trim[7:0] == $past(reg_wdata[7:0]));
   endproperty
   a_trim_fields: assert property (p_trim_fields) else $error("offset trims wrong"); // [RULE14]

   // timing low bits take the write, rest stays zero
   property p_timing_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[13] |=> (detector_pump_timing[6:0] == $past(reg_wdata[6:0]))
         && (detector_pump_timing[15:7] == 9'h000);
   endproperty
   a_timing_fields: assert property (p_timing_fields) else $error("timing fields wrong"); // [RULE15]

   // dither enable, magnitude and seed top bit
   property p_dither_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[14] |=> (dither_control[3:0] == $past(reg_wdata[3:0]))
         && (dither_control[15:4] == 12'h000);
   endproperty
   a_dither_fields: assert property (p_dither_fields) else $error("dither fields wrong"); // [RULE16]

   // seed low word is fully writable
   property p_seed_word;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[15] |=>
         dither_seed_low == $past(reg_wdata);
   endproperty
   a_seed_word: assert property (p_seed_word) else $error("seed word wrong"); // [RULE17]

   // tune control, band source and band value
   property p_band_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[16] |=> (oscillator_band_control[9:0] == $past(reg_wdata[9:0]))
         && (oscillator_band_control[15:10] == 6'h00);
   endproperty
   a_band_fields: assert property (p_band_fields) else $error("band fields wrong"); // [RULE18]

   // both setting fields take the write, top bits stay zero
   property p_settings_fields;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[17] |=> (oscillator_settings[13:0] == $past(reg_wdata[13:0]))
         && (oscillator_settings[15:14] == 2'h0);
   endproperty
   a_settings_fields: assert property (p_settings_fields) else $error("setting fields wrong"); // [RULE19]

   // unmapped offsets answer zero
   property p_unmapped_read;
      @(posedge clk) disable iff (!rst_n)
      (reg_read && (rd_hit == '0)) |=>
         reg_rvalid && (reg_rdata == 16'h0000);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero"); // [RULE21]

   // no answer without a strobe
   property p_rvalid_pulse;
      @(posedge clk) disable iff (!rst_n)
      !reg_read |=>
         !reg_rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray read answer"); // [RULE21]

   // read data holds between reads
   property p_rdata_hold;
      @(posedge clk) disable iff (!rst_n)
      !reg_read |=>
         $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [RULE21]

   // mode outputs follow the written mode bit
   property p_mode_write;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[IDX_INT] |=>
         integer_mode == $past(reg_wdata[DIV_MODE_BIT]);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode bit not taken"); // [RULE4]

   // reset word with trigger clear does nothing
   property p_swrst_nowrite;
      @(posedge clk) disable iff (!rst_n)
      (wr_hit[IDX_SWRST] && !reg_wdata[SWRST_BIT]) |=>
         !soft_reset_pulse;
   endproperty
   a_swrst_nowrite: assert property (p_swrst_nowrite) else $error("soft reset without trigger"); // [RULE1]

   // soft reset reaches the far end of the bank too
   property p_soft_all;
      @(posedge clk) disable iff (!rst_n)
      soft_hit |=> (oscillator_settings == REG_RESET[17]) && (dither_control == REG_RESET[14])
         && (modulator_linearity == REG_RESET[10]);
   endproperty
   a_soft_all: assert property (p_soft_all) else $error("soft reset missed words"); // [RULE20]

   // fraction alone lands whole
   property p_frac_write;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[IDX_FRAC] |=>
         fractional_divider == $past(reg_wdata);
   endproperty
   a_frac_write: assert property (p_frac_write) else $error("fraction write wrong"); // [RULE5]

   // modulus alone lands whole
   property p_modu_write;
      @(posedge clk) disable iff (!rst_n)
      wr_hit[IDX_MODU] |=>
         divider_modulus == $past(reg_wdata);
   endproperty
   a_modu_write: assert property (p_modu_write) else $error("modulus write wrong"); // [RULE6]

   // soft reset restores mask and modulus
   property p_mask_soft;
      @(posedge clk) disable iff (!rst_n)
      soft_hit |=> (power_enable_mask == REG_RESET[IDX_MASK])
         && (divider_modulus == REG_RESET[IDX_MODU]);
   endproperty
   a_mask_soft: assert property (p_mask_soft) else $error("soft reset missed mask"); // [RULE20]
endmodule : mpr_register_bank
`default_nettype wire
